// *** shared/seb_pkg.sv ***
// Functional notes
// - Master-select bit 5 of first_control_low set makes the port master, driving clock.
// - Master-select bit 5 cleared makes the port a slave clocked from outside.
// - Receive overflow flag sits at status_low bit 6; software clears before enabling.
// - Buffered-mode select bit 0 chooses enhanced queues instead of single buffer.
// - Nothing runs until enable bit 15 is set; software sets it last.
// - A master starts shifting as soon as the upper transmit buffer half is written.
// - With clock-edge select set in slave mode, slave-select enable must be set.
package seb_pkg;
   localparam int DATA_W = 32;
   localparam int HALF_W = 16;
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_CON1L = 8'h00;
   localparam logic [7:0] OFS_CON1H = 8'h04;
   localparam logic [7:0] OFS_CON2L = 8'h08;
   localparam logic [7:0] OFS_STATL = 8'h0C;
   localparam logic [7:0] OFS_BUFL = 8'h10;
   localparam logic [7:0] OFS_BUFH = 8'h14;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;
   // first_control_low fields
   localparam int C1L_PORT_ENABLE = 15;
   localparam int C1L_SAMPLE_PHASE = 9;
   localparam int C1L_CLOCK_EDGE = 8;
   localparam int C1L_SS_ENABLE = 7;
   localparam int C1L_CLOCK_IDLE = 6;
   localparam int C1L_MASTER_SELECT = 5;
   localparam int C1L_BUFFERED_MODE = 0;
   // status_low fields
   localparam int ST_RX_NOT_EMPTY = 0;
   localparam int ST_TX_FULL = 1;
   localparam int ST_BUSY = 4;
   localparam int ST_RX_OVERFLOW = 6;
   localparam logic [15:0] CTRL_RST = 16'h0000;
   // Queue geometry
   localparam int DEPTH = 4;
   localparam int PTR_W = 2;
   localparam int CNT_W = 3;
   localparam logic [CNT_W-1:0] CNT_DEPTH = 3'h4;
   localparam logic [CNT_W-1:0] CNT_SINGLE = 3'h1;
   localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
   localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
   // Serial timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int SCLK_HALF_NS = 32;
   localparam int SCLK_HALF_CYC =
      (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] DIV_LAST = 3'(SCLK_HALF_CYC - 1);
   localparam logic [5:0] BIT_LAST = 6'(DATA_W - 1);
   localparam logic [6:0] EDGE_TOTAL = 7'(2 * DATA_W);
   // Interrupt event bits
   localparam int EV_W = 3;
   typedef struct packed {
      logic rxOverflow;
      logic txEmpty;
      logic rxDone;
   } seb_evt_t;
   typedef struct packed {
      logic sclk;
      logic sdi;
      logic ssN;
   } seb_pins_t;
   localparam seb_pins_t PINS_RST = 3'h1;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_MASTER = 2'b01,
      ST_SLAVE = 2'b10
   } seb_state_t;
endpackage

// *** design/seb_shifter.sv ***
`timescale 1ns/1ps
module seb_shifter (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Control
   input wire logic load,
   input wire logic [seb_pkg::DATA_W-1:0] loadWord,
   input wire logic sampleEv,
   input wire logic shiftEv,
   input wire logic sdi,
   // Results
   output logic sdo,
   output logic done,
   output logic [seb_pkg::DATA_W-1:0] rxWord
);
   logic [seb_pkg::DATA_W-1:0] txShift_reg;
   logic [seb_pkg::DATA_W-1:0] rxShift_reg;
   logic [5:0] bitCnt_reg;
   logic done_reg;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         txShift_reg <= '0;
         rxShift_reg <= '0;
         bitCnt_reg <= '0;
         done_reg <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         if (load) begin
            txShift_reg <= loadWord;
            bitCnt_reg <= '0;
         end else begin
            if (sampleEv) begin
               rxShift_reg <= {rxShift_reg[seb_pkg::DATA_W-2:0], sdi};
               bitCnt_reg <= bitCnt_reg + 6'h01;
               if (bitCnt_reg == seb_pkg::BIT_LAST) begin
                  done_reg <= 1'b1;
               end
            end
            if (shiftEv) begin
               txShift_reg <= {txShift_reg[seb_pkg::DATA_W-2:0], 1'b0};
            end
         end
      end
   end

   assign sdo = txShift_reg[seb_pkg::DATA_W-1];
   assign done = done_reg;
   assign rxWord = rxShift_reg;
endmodule

// *** design/seb_top.sv ***
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
module seb_top (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // APB slave
   input wire logic [seb_pkg::ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [seb_pkg::DATA_W-1:0] pwdata,
   output logic [seb_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial link
   input wire logic sclkIn,
   input wire logic sdi,
   input wire logic slaveSelectPinN,
   output logic sclkOut,
   output logic sclkOe,
   output logic sdo,
   // Interrupt
   output logic irq
);
   function automatic logic isReg(input logic [7:0] a,
                                  input logic [7:0] ofs);
      return a == ofs;
   endfunction

   // Pin synchronisers
   seb_pkg::seb_pins_t pinRaw;
   seb_pkg::seb_pins_t pinMeta_reg;
   seb_pkg::seb_pins_t pinSync_reg;
   logic sclkPrev_reg;

   assign pinRaw = '{sclk: sclkIn, sdi: sdi, ssN: slaveSelectPinN};

   generate
      for (genvar i = 0; i < 3; i++) begin : g_sync
         always_ff @(posedge ref_clk or posedge reset) begin
            if (reset) begin
               pinMeta_reg[i] <= seb_pkg::PINS_RST[i];
               pinSync_reg[i] <= seb_pkg::PINS_RST[i];
            end else begin
               pinMeta_reg[i] <= pinRaw[i];
               pinSync_reg[i] <= pinMeta_reg[i];
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         sclkPrev_reg <= 1'b0;
      end else begin
         sclkPrev_reg <= pinSync_reg.sclk;
      end
   end

   // Control registers
   logic [15:0] con1l_reg;
   logic [15:0] con1h_reg;
   logic [15:0] con2l_reg;
   logic [15:0] txLow_reg;
   logic portEnable;
   logic isMaster;
   logic bufferedMode;
   logic clockEdge;
   logic clockIdle;
   logic ssEnable;
   logic [seb_pkg::CNT_W-1:0] limit;

   assign portEnable = con1l_reg[seb_pkg::C1L_PORT_ENABLE];
   assign isMaster = con1l_reg[seb_pkg::C1L_MASTER_SELECT];
   assign bufferedMode = con1l_reg[seb_pkg::C1L_BUFFERED_MODE];
   assign clockEdge = con1l_reg[seb_pkg::C1L_CLOCK_EDGE];
   assign clockIdle = con1l_reg[seb_pkg::C1L_CLOCK_IDLE];
   assign ssEnable = con1l_reg[seb_pkg::C1L_SS_ENABLE];
   // Enhanced mode opens the full queue depth
   assign limit = bufferedMode ? seb_pkg::CNT_DEPTH :
                  seb_pkg::CNT_SINGLE;

   // APB handshake: one wait state, answer registered
   logic pready_reg;
   logic pslverr_reg;
   logic [seb_pkg::DATA_W-1:0] prdata_reg;
   logic access;
   logic wrDone;
   logic rdDone;
   logic mapped;

   assign access = psel & penable & ~pready_reg;
   assign wrDone = psel & penable & pready_reg & pwrite;
   assign rdDone = psel & penable & pready_reg & ~pwrite;
   assign mapped = isReg(paddr, seb_pkg::OFS_CON1L) |
                   isReg(paddr, seb_pkg::OFS_CON1H) |
                   isReg(paddr, seb_pkg::OFS_CON2L) |
                   isReg(paddr, seb_pkg::OFS_STATL) |
                   isReg(paddr, seb_pkg::OFS_BUFL) |
                   isReg(paddr, seb_pkg::OFS_BUFH) |
                   isReg(paddr, seb_pkg::OFS_IRQ_STAT) |
                   isReg(paddr, seb_pkg::OFS_IRQ_MASK);

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         con1l_reg <= seb_pkg::CTRL_RST;
         con1h_reg <= seb_pkg::CTRL_RST;
         con2l_reg <= seb_pkg::CTRL_RST;
         txLow_reg <= seb_pkg::CTRL_RST;
      end else if (wrDone) begin
         if (isReg(paddr, seb_pkg::OFS_CON1L)) begin
            con1l_reg <= pwdata[15:0];
         end
         if (isReg(paddr, seb_pkg::OFS_CON1H)) begin
            con1h_reg <= pwdata[15:0];
         end
         if (isReg(paddr, seb_pkg::OFS_CON2L)) begin
            con2l_reg <= pwdata[15:0];
         end
         if (isReg(paddr, seb_pkg::OFS_BUFL)) begin
            txLow_reg <= pwdata[15:0];
         end
      end
   end

   // Transmit queue
   logic [seb_pkg::DATA_W-1:0] txMem [seb_pkg::DEPTH];
   logic [seb_pkg::PTR_W-1:0] txWr_reg;
   logic [seb_pkg::PTR_W-1:0] txRd_reg;
   logic [seb_pkg::CNT_W-1:0] txCount_reg;
   logic txPush;
   logic txPop;
   logic txFlush;
   logic txFull;

   assign txFull = txCount_reg >= limit;
   // Writing a data buffer while disabled clears stale words
   assign txFlush = wrDone & ~portEnable &
                    (isReg(paddr, seb_pkg::OFS_BUFL) |
                     isReg(paddr, seb_pkg::OFS_BUFH));
   // Upper half completes the word and queues it
   assign txPush = wrDone & portEnable & ~txFull &
                   isReg(paddr, seb_pkg::OFS_BUFH);

   always_ff @(posedge ref_clk) begin
      if (txPush) begin
         txMem[txWr_reg] <= {pwdata[15:0], txLow_reg};
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         txWr_reg <= '0;
         txRd_reg <= '0;
         txCount_reg <= seb_pkg::CNT_ZERO;
      end else if (txFlush) begin
         txWr_reg <= '0;
         txRd_reg <= '0;
         txCount_reg <= seb_pkg::CNT_ZERO;
      end else begin
         if (txPush) begin
            txWr_reg <= txWr_reg + 2'h1;
         end
         if (txPop) begin
            txRd_reg <= txRd_reg + 2'h1;
         end
         if (txPush & ~txPop) begin
            txCount_reg <= txCount_reg + seb_pkg::CNT_ONE;
         end else if (txPop & ~txPush) begin
            txCount_reg <= txCount_reg - seb_pkg::CNT_ONE;
         end
      end
   end

   // Receive queue
   logic [seb_pkg::DATA_W-1:0] rxMem [seb_pkg::DEPTH];
   logic [seb_pkg::PTR_W-1:0] rxWr_reg;
   logic [seb_pkg::PTR_W-1:0] rxRd_reg;
   logic [seb_pkg::CNT_W-1:0] rxCount_reg;
   logic [seb_pkg::DATA_W-1:0] rxWord;
   logic [seb_pkg::DATA_W-1:0] rxHead;
   logic shiftDone;
   logic rxPush;
   logic rxPop;
   logic rxLost;

   assign rxHead = rxMem[rxRd_reg];
   assign rxPush = shiftDone & (rxCount_reg < limit);
   assign rxLost = shiftDone & (rxCount_reg >= limit);
   assign rxPop = rdDone & isReg(paddr, seb_pkg::OFS_BUFH) &
                  (rxCount_reg != seb_pkg::CNT_ZERO);

   always_ff @(posedge ref_clk) begin
      if (rxPush) begin
         rxMem[rxWr_reg] <= rxWord;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rxWr_reg <= '0;
         rxRd_reg <= '0;
         rxCount_reg <= seb_pkg::CNT_ZERO;
      end else begin
         if (rxPush) begin
            rxWr_reg <= rxWr_reg + 2'h1;
         end
         if (rxPop) begin
            rxRd_reg <= rxRd_reg + 2'h1;
         end
         if (rxPush & ~rxPop) begin
            rxCount_reg <= rxCount_reg + seb_pkg::CNT_ONE;
         end else if (rxPop & ~rxPush) begin
            rxCount_reg <= rxCount_reg - seb_pkg::CNT_ONE;
         end
      end
   end

   // Transfer control
   seb_pkg::seb_state_t state_reg;
   logic [2:0] div_reg;
   logic [6:0] edgeCnt_reg;
   logic sclk_reg;
   logic tick;
   logic slaveRise;
   logic slaveFall;
   logic ssActive;
   logic linkEdge;
   logic leadEdge;
   logic load;
   logic [seb_pkg::DATA_W-1:0] loadWord;
   logic sampleEv;
   logic shiftEv;

   assign tick = (state_reg == seb_pkg::ST_MASTER) &&
                 (div_reg == seb_pkg::DIV_LAST);
   assign slaveRise = pinSync_reg.sclk & ~sclkPrev_reg;
   assign slaveFall = ~pinSync_reg.sclk & sclkPrev_reg;
   // Pin is honoured only when slave-select is enabled
   assign ssActive = ~ssEnable | ~pinSync_reg.ssN;
   assign linkEdge = (state_reg == seb_pkg::ST_MASTER) ?
                     (tick && edgeCnt_reg != seb_pkg::EDGE_TOTAL) :
                     (state_reg == seb_pkg::ST_SLAVE) &
                     (slaveRise | slaveFall);
   assign leadEdge = (state_reg == seb_pkg::ST_MASTER) ?
                     (sclk_reg == clockIdle) :
                     (clockIdle ? slaveFall : slaveRise);
   assign sampleEv = linkEdge & (clockEdge ? leadEdge : ~leadEdge);
   // The first edge never shifts: the top bit is already out
   assign shiftEv = linkEdge & (clockEdge ? ~leadEdge : leadEdge) &
                    (edgeCnt_reg != 7'h00);
   assign load = (state_reg == seb_pkg::ST_IDLE) & portEnable &
                 (isMaster ? (txCount_reg != seb_pkg::CNT_ZERO) :
                  ssActive);
   assign txPop = load & (txCount_reg != seb_pkg::CNT_ZERO);
   // An empty slave queue sends zeros rather than stale data
   assign loadWord = txPop ? txMem[txRd_reg] : '0;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state_reg <= seb_pkg::ST_IDLE;
         div_reg <= '0;
         edgeCnt_reg <= '0;
      end else if (~portEnable) begin
         state_reg <= seb_pkg::ST_IDLE;
         div_reg <= '0;
         edgeCnt_reg <= '0;
      end else begin
         case (state_reg)
            seb_pkg::ST_IDLE: begin
               div_reg <= '0;
               edgeCnt_reg <= '0;
               if (load && isMaster) begin
                  state_reg <= seb_pkg::ST_MASTER;
               end else if (load) begin
                  state_reg <= seb_pkg::ST_SLAVE;
               end
            end
            seb_pkg::ST_MASTER: begin
               div_reg <= tick ? 3'h0 : div_reg + 3'h1;
               if (linkEdge) begin
                  edgeCnt_reg <= edgeCnt_reg + 7'h01;
               end
               if (tick && edgeCnt_reg == seb_pkg::EDGE_TOTAL) begin
                  state_reg <= seb_pkg::ST_IDLE;
               end
            end
            seb_pkg::ST_SLAVE: begin
               if (linkEdge) begin
                  edgeCnt_reg <= edgeCnt_reg + 7'h01;
               end
               if (~ssActive ||
                   edgeCnt_reg == seb_pkg::EDGE_TOTAL) begin
                  state_reg <= seb_pkg::ST_IDLE;
               end
            end
            default: begin
               state_reg <= seb_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Master clock drive; slave leaves the clock pin released
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         sclk_reg <= 1'b0;
         sclkOe <= 1'b0;
      end else begin
         sclkOe <= portEnable & isMaster;
         if (state_reg != seb_pkg::ST_MASTER) begin
            sclk_reg <= clockIdle;
         end else if (linkEdge) begin
            sclk_reg <= ~sclk_reg;
         end
      end
   end

   assign sclkOut = sclk_reg;

   seb_shifter u_shifter (
      .ref_clk(ref_clk),
      .reset(reset),
      .load(load),
      .loadWord(loadWord),
      .sampleEv(sampleEv),
      .shiftEv(shiftEv),
      .sdi(pinSync_reg.sdi),
      .sdo(sdo),
      .done(shiftDone),
      .rxWord(rxWord)
   );

   // Overflow flag and interrupt status; a new event beats a clear
   logic rov_reg;
   logic [seb_pkg::EV_W-1:0] irqStat_reg;
   logic [seb_pkg::EV_W-1:0] irqMask_reg;
   seb_pkg::seb_evt_t evt;

   assign evt = '{rxOverflow: rxLost,
                  txEmpty: txPop & (txCount_reg == seb_pkg::CNT_ONE),
                  rxDone: shiftDone};

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rov_reg <= 1'b0;
      end else if (rxLost) begin
         rov_reg <= 1'b1;
      end else if (wrDone && isReg(paddr, seb_pkg::OFS_STATL) &&
                   pwdata[seb_pkg::ST_RX_OVERFLOW]) begin
         rov_reg <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         irqStat_reg <= '0;
         irqMask_reg <= '0;
      end else begin
         if (wrDone && isReg(paddr, seb_pkg::OFS_IRQ_MASK)) begin
            irqMask_reg <= pwdata[seb_pkg::EV_W-1:0];
         end
         if (wrDone && isReg(paddr, seb_pkg::OFS_IRQ_STAT)) begin
            irqStat_reg <= (irqStat_reg & ~pwdata[seb_pkg::EV_W-1:0])
                           | evt;
         end else begin
            irqStat_reg <= irqStat_reg | evt;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irqStat_reg & irqMask_reg);
      end
   end

   // Read answer, captured in the cycle before pready
   logic [15:0] statWord;

   always_comb begin
      statWord = '0;
      statWord[seb_pkg::ST_RX_OVERFLOW] = rov_reg;
      statWord[seb_pkg::ST_BUSY] = state_reg != seb_pkg::ST_IDLE;
      statWord[seb_pkg::ST_TX_FULL] = txFull;
      statWord[seb_pkg::ST_RX_NOT_EMPTY] =
         rxCount_reg != seb_pkg::CNT_ZERO;
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= '0;
      end else begin
         pready_reg <= access;
         pslverr_reg <= access & ~mapped;
         if (access & ~pwrite) begin
            case (paddr)
               seb_pkg::OFS_CON1L: prdata_reg <= {16'h0000, con1l_reg};
               seb_pkg::OFS_CON1H: prdata_reg <= {16'h0000, con1h_reg};
               seb_pkg::OFS_CON2L: prdata_reg <= {16'h0000, con2l_reg};
               seb_pkg::OFS_STATL: prdata_reg <= {16'h0000, statWord};
               seb_pkg::OFS_BUFL: begin
                  prdata_reg <= {16'h0000, rxHead[15:0]};
               end
               seb_pkg::OFS_BUFH: begin
                  prdata_reg <= {16'h0000, rxHead[31:16]};
               end
               seb_pkg::OFS_IRQ_STAT: begin
                  prdata_reg <= 32'(irqStat_reg);
               end
               seb_pkg::OFS_IRQ_MASK: begin
                  prdata_reg <= 32'(irqMask_reg);
               end
               default: prdata_reg <= '0;
            endcase
         end else begin
            // Data stands only with pready, zero otherwise
            prdata_reg <= '0;
         end
      end
   end

   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign prdata = prdata_reg;
endmodule

// *** tb/seb_chk.sv ***
`timescale 1ns/1ps
module seb_chk (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Register bus
   input wire logic psel,
   input wire logic penable,
   input wire logic [seb_pkg::DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Link and interrupt
   input wire logic slaveSelectPinN,
   input wire logic sclkOut,
   input wire logic sclkOe,
   input wire logic sdo,
   input wire logic irq
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held for more than one cycle");
   a_ready_timing: assert property ((psel && !penable) ##1 (psel && penable)
      |-> !pready ##1 pready)
      else $error("access phase not answered in its second cycle");
   a_ready_in_access: assert property (pready |-> psel && penable)
      else $error("ready outside an access phase");
   a_slverr_with_ready: assert property (pslverr |-> pready)
      else $error("error response without ready");
   a_rdata_quiet: assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("read data not zero outside a response");
   a_sclk_half: assert property ($changed(sclkOut) |=> $stable(sclkOut)[*3])
      else $error("serial clock half period not four cycles");
   a_sclk_master: assert property ($rose(sclkOut) |-> sclkOe)
      else $error("serial clock driven while not master");
   a_sclk_idle: assert property (!sclkOe |-> !sclkOut)
      else $error("serial clock away from idle while released");
   a_sdo_hold: assert property ($fell(sclkOut) |-> $stable(sdo))
      else $error("serial data moved at the sampling edge");
   c_slverr: cover property (pslverr);
   c_irq: cover property ($rose(irq));
   c_master: cover property ($rose(sclkOe));
   c_select: cover property ($fell(slaveSelectPinN));
endmodule

// *** tb/seb_partner.sv ***
`timescale 1ns/1ps
module seb_partner (
   // From the port
   input wire logic sclkOut,
   input wire logic sclkOe,
   input wire logic sdo,
   // Far end drives
   output logic sclkIn,
   output logic sdi,
   output logic slaveSelectPinN
);
   logic [31:0] txQ[$];
   logic [31:0] capQ[$];
   logic [31:0] sh = 32'h0000_0000;
   logic [31:0] cap = 32'h0000_0000;
   int cnt = 0;
   initial begin
      sclkIn = 1'b0;
      sdi = 1'b1;
      slaveSelectPinN = 1'b1;
   end
   // Slave role: new word at the first leading edge, shift on later ones
   always @(posedge sclkOut) begin
      if (cnt == 0)
         sh = (txQ.size() > 0) ? txQ.pop_front() : ~sh;
      else
         sh = sh << 1;
      sdi = sh[31];
   end
   always @(negedge sclkOut) begin
      cap = {cap[30:0], sdo};
      cnt = cnt + 1;
      if (cnt == 32) begin
         capQ.push_back(cap);
         cnt = 0;
         sdi = ~sdi;
      end
   end
   always @(negedge sclkOe) cnt = 0;
   // Master role: one 32-bit frame, 64 ns link clock
   task automatic frame(input bit cke, input bit sel, input logic [31:0] w,
                        output logic [31:0] got);
      #3 slaveSelectPinN = ~sel;
      #64;
      for (int i = 31; i >= 0; i--) begin
         sdi = w[i];
         #16 sclkIn = 1'b1;
         #28 if (cke) got[i] = sdo;
         #4 sclkIn = 1'b0;
         #12 if (!cke) got[i] = sdo;
         #4;
      end
      #32 slaveSelectPinN = 1'b1;
      sdi = ~sdi;
   endtask
endmodule

// *** tb/seb_tb_top.sv ***
`timescale 1ns/1ps
module seb_tb_top;
   // Clock, reset and bus
   logic ref_clk;
   logic reset;
   logic [7:0] paddr;
   logic psel;
   logic penable;
   logic pwrite;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   // Link and interrupt
   wire sclkIn;
   wire sdi;
   wire slaveSelectPinN;
   logic sclkOut;
   logic sclkOe;
   logic sdo;
   logic irq;
   int numErrors = 0;
   int totalChecks = 0;
   logic [31:0] rdat;
   logic rerr;
   logic [31:0] expQ[$];
   localparam logic [31:0] EN = 32'h0000_8000;
   localparam logic [31:0] MS = 32'h0000_0020;
   localparam logic [31:0] CKE = 32'h0000_0100;
   localparam logic [31:0] SSE = 32'h0000_0080;
   localparam logic [31:0] OVF = 32'h0000_0040;
   localparam logic [31:0] LO = 32'h0000_FFFF;
   seb_top i_seb_top (
      .ref_clk(ref_clk), .reset(reset), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sclkIn(sclkIn), .sdi(sdi),
      .slaveSelectPinN(slaveSelectPinN), .sclkOut(sclkOut),
      .sclkOe(sclkOe), .sdo(sdo), .irq(irq)
   );
   seb_partner i_seb_partner (
      .sclkOut(sclkOut), .sclkOe(sclkOe), .sdo(sdo), .sclkIn(sclkIn),
      .sdi(sdi), .slaveSelectPinN(slaveSelectPinN)
   );
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         numErrors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) numErrors++;
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      check(rdat, e);
   endtask
   task automatic finish_test();
      if (numErrors == 0 && totalChecks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   initial begin
      #300_000;
      numErrors++;
      finish_test();
   end
   initial begin
      logic [31:0] tx;
      logic [31:0] rx;
      logic [31:0] got;
      int depth;
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      void'($urandom(32'hffc5_a4a1));
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      rd(seb_pkg::OFS_CON1L, 32'h0000_0000);
      rd(seb_pkg::OFS_STATL, 32'h0000_0000);
      rd(8'h20, 32'h0000_0000);
      check(32'(rerr), 32'h0000_0001);
      for (int m = 1; m >= 0; m--) begin
         depth = (m == 1) ? seb_pkg::DEPTH : 1;
         tx = $urandom;
         wr(seb_pkg::OFS_CON1L, 32'h0000_0000);
         wr(seb_pkg::OFS_IRQ_STAT, 32'h0000_0007);
         wr(seb_pkg::OFS_IRQ_MASK, 32'h0000_0007);
         wr(seb_pkg::OFS_CON1H, tx & LO);
         wr(seb_pkg::OFS_CON2L, ~tx & LO);
         rd(seb_pkg::OFS_CON1H, tx & LO);
         wr(seb_pkg::OFS_CON1L, MS);
         wr(seb_pkg::OFS_STATL, OVF);
         wr(seb_pkg::OFS_CON1L, MS | 32'(m));
         wr(seb_pkg::OFS_CON1L, MS | 32'(m) | EN);
         repeat (2) @(posedge ref_clk);
         check(32'(sclkOe), 32'h0000_0001);
         for (int k = 0; k <= depth; k++) begin
            tx = $urandom;
            rx = $urandom;
            i_seb_partner.txQ.push_back(rx);
            if (k < depth) expQ.push_back(rx);
            wr(seb_pkg::OFS_BUFL, tx & LO);
            wr(seb_pkg::OFS_BUFH, tx >> 16);
            for (int n = 0; n < 1000 && i_seb_partner.capQ.size() == 0; n++)
               @(posedge ref_clk);
            got = (i_seb_partner.capQ.size() > 0) ?
               i_seb_partner.capQ.pop_front() : 32'hxxxx_xxxx;
            check(got, tx);
         end
         repeat (10) @(posedge ref_clk);
         rd(seb_pkg::OFS_STATL, 32'h0000_0041);
         check(32'(irq), 32'h0000_0001);
         rd(seb_pkg::OFS_IRQ_STAT, 32'h0000_0007);
         wr(seb_pkg::OFS_IRQ_MASK, 32'h0000_0000);
         repeat (2) @(posedge ref_clk);
         check(32'(irq), 32'h0000_0000);
         while (expQ.size() > 0) begin
            rx = expQ.pop_front();
            rd(seb_pkg::OFS_BUFL, rx & LO);
            rd(seb_pkg::OFS_BUFH, rx >> 16);
         end
         rd(seb_pkg::OFS_STATL, OVF);
         wr(seb_pkg::OFS_STATL, OVF);
         wr(seb_pkg::OFS_IRQ_STAT, 32'h0000_0007);
         rd(seb_pkg::OFS_STATL, 32'h0000_0000);
      end
      wr(seb_pkg::OFS_CON1L, 32'h0000_0000);
      wr(seb_pkg::OFS_BUFL, 32'h0000_0000);
      wr(seb_pkg::OFS_BUFH, 32'h0000_0000);
      wr(seb_pkg::OFS_CON1L, SSE | CKE);
      wr(seb_pkg::OFS_STATL, OVF);
      wr(seb_pkg::OFS_CON1L, SSE | CKE | 32'h0000_0001);
      wr(seb_pkg::OFS_CON1L, SSE | CKE | 32'h0000_0001 | EN);
      repeat (2) @(posedge ref_clk);
      check(32'(sclkOe), 32'h0000_0000);
      tx = $urandom;
      rx = $urandom;
      wr(seb_pkg::OFS_BUFL, tx & LO);
      wr(seb_pkg::OFS_BUFH, tx >> 16);
      i_seb_partner.frame(1'b1, 1'b0, rx, got);
      rd(seb_pkg::OFS_STATL, 32'h0000_0000);
      i_seb_partner.frame(1'b1, 1'b1, rx, got);
      check(got, tx);
      repeat (10) @(posedge ref_clk);
      rd(seb_pkg::OFS_BUFL, rx & LO);
      rd(seb_pkg::OFS_BUFH, rx >> 16);
      finish_test();
   end
endmodule
bind seb_top seb_chk i_seb_chk (
   .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .slaveSelectPinN(slaveSelectPinN), .sclkOut(sclkOut),
   .sclkOe(sclkOe), .sdo(sdo), .irq(irq)
);
